// [src/rscl_top.v]
// Reset sequencer, strap latch, reset pin drivers and power mode entry.
// Assumes all pins are synchronous to the CPU clock; rst_n_i is power-on reset.
//
// Added by the designer: register access over Wishbone and the address map.
`include "rscl_defines.vh"

module rscl_top (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire reset_input_pin_n_i,
   output wire reset_input_pin_o,
   output wire reset_input_pin_oe_o,
   output wire reset_output_pin_n_o,
   input wire reset_delay_pin_high_i,
   output wire reset_delay_pulldown_o,
   output wire reset_delay_pullup_o,
   input wire [15:0] boot_strap_port_i,
   input wire external_access_pin_i,
   input wire sw_reset_i,
   input wire wdt_reset_i,
   input wire einit_i,
   input wire idle_instr_i,
   input wire power_down_instruction_i,
   input wire wake_irq_i,
   input wire bus_pending_i,
   input wire bus_access_end_i,
   input wire ready_enable_i,
   input wire ready_polarity_i,
   input wire ready_pin_i,
   output wire core_reset_o,
   output reg reset_async_o,
   output reg [2:0] clock_config_strap_o,
   output reg [1:0] segment_address_line_select_o,
   output reg [1:0] chip_select_count_select_o,
   output reg write_config_strap_o,
   output reg bootloader_select_o,
   output reg adapt_mode_select_o,
   output reg emulation_mode_o,
   output wire cpu_stop_o,
   output wire periph_stop_o,
   output reg mode_refused_o
);
   localparam S_START = 3'h0;
   localparam S_SEQ = 3'h1;
   localparam S_WAIT = 3'h2;
   localparam S_LATCH = 3'h3;
   localparam S_RUN = 3'h4;
   localparam integer LATCH_LAST = `RSCL_LATCH_CYC - 1;
   localparam M_RUN = 2'h0;
   localparam M_PEND = 2'h1;
   localparam M_IDLE = 2'h2;
   localparam M_PDOWN = 2'h3;

   reg [2:0] state;
   reg [2:0] kind;
   reg [2:0] latch_cnt;
   reg pull_active;
   reg bidir_reset_enable;
   reg powerdown_config_bit;
   reg einit_done;
   reg [15:0] strap_raw;
   reg [1:0] bus_type_field;
   reg bus_active_zero;
   reg latch_lengthen_zero;
   reg [1:0] mode;
   reg pend_pdown;
   reg ready_ok;
   wire seq_start;
   wire seq_busy;
   wire seq_done;
   wire hw_req;
   wire soft_req;
   wire [15:0] mask;
   wire [15:0] clr;
   wire [15:0] reset_strap_latch;
   wire high_byte_disable;
   wire write_signal_config;
   wire [15:0] system_config_register;
   wire [15:0] bus_config_register_zero;
   wire [15:0] status_reg;
   wire wr;

   function [15:0] strap_mask;
      input [2:0] k;
      begin
         if (k == `RSCL_KIND_SW || k == `RSCL_KIND_WDT) begin
            strap_mask = `RSCL_MASK_SOFT;
         end else if (k == `RSCL_KIND_SHORT) begin
            strap_mask = `RSCL_MASK_SHORT;
         end else begin
            strap_mask = `RSCL_MASK_ALL;
         end
      end
   endfunction

   assign mask = strap_mask(kind);
   assign clr = (kind == `RSCL_KIND_SW || kind == `RSCL_KIND_WDT) ? `RSCL_CLR_SOFT : 16'h0000;
   assign hw_req = (state == S_RUN) && !reset_input_pin_n_i;
   assign soft_req = (state == S_RUN) && (sw_reset_i || wdt_reset_i);
   assign seq_start = (state == S_START) || hw_req || soft_req;

   rscl_seq_timer #(
      .CYCLES(`RSCL_SEQ_CYC)
   ) u_timer (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .start_i(seq_start),
      .busy_o(seq_busy),
      .done_o(seq_done)
   );

   // Reset sequence: start, fixed count, wait for pin high, delayed strap latch.
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state <= S_START;
         kind <= `RSCL_KIND_POR;
         reset_async_o <= 1'b1;
         pull_active <= 1'b0;
         latch_cnt <= 3'h0;
      end else begin
         case (state)
            S_START: begin
               state <= S_SEQ;
            end
            S_SEQ: begin
               if (!reset_delay_pin_high_i) begin
                  pull_active <= 1'b0;
                  reset_async_o <= 1'b1;
               end
               if (seq_done) begin
                  pull_active <= 1'b0;
                  state <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (reset_input_pin_n_i) begin
                  latch_cnt <= LATCH_LAST[2:0];
                  state <= S_LATCH;
               end else begin
                  if (kind != `RSCL_KIND_POR) begin
                     kind <= `RSCL_KIND_LONG;
                  end
                  reset_async_o <= !reset_delay_pin_high_i;
               end
            end
            S_LATCH: begin
               if (latch_cnt == 3'h0) begin
                  state <= S_RUN;
               end else begin
                  latch_cnt <= latch_cnt - 3'h1;
               end
            end
            S_RUN: begin
               if (hw_req) begin
                  state <= S_SEQ;
                  kind <= `RSCL_KIND_SHORT;
                  reset_async_o <= !reset_delay_pin_high_i;
                  pull_active <= bidir_reset_enable;
               end else if (soft_req) begin
                  state <= S_SEQ;
                  reset_async_o <= 1'b0;
                  pull_active <= bidir_reset_enable;
                  if (bidir_reset_enable) begin
                     kind <= `RSCL_KIND_SHORT;
                  end else if (sw_reset_i) begin
                     kind <= `RSCL_KIND_SW;
                  end else begin
                     kind <= `RSCL_KIND_WDT;
                  end
               end
            end
            default: begin
               state <= S_START;
            end
         endcase
      end
   end

   assign reset_input_pin_o = 1'b0;
   assign reset_input_pin_oe_o = pull_active && seq_busy;
   assign core_reset_o = (state != S_RUN);
   assign reset_output_pin_n_o = einit_done;
   assign reset_delay_pulldown_o = !reset_input_pin_n_i;
   assign reset_delay_pullup_o = powerdown_config_bit && (state == S_RUN);

   // Strap capture at the end of the latch delay.
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         strap_raw <= 16'h0000;
      end else if (state == S_LATCH && latch_cnt == 3'h0) begin
         strap_raw <= (strap_raw & ~mask & ~clr) | (boot_strap_port_i & mask);
      end
   end

   assign reset_strap_latch = {8'h00, strap_raw[15:8]};

   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         clock_config_strap_o <= 3'h0;
         segment_address_line_select_o <= 2'h0;
         chip_select_count_select_o <= 2'h0;
         write_config_strap_o <= 1'b0;
         bootloader_select_o <= 1'b0;
         adapt_mode_select_o <= 1'b0;
         emulation_mode_o <= 1'b0;
      end else begin
         clock_config_strap_o <= strap_raw[15:13];
         segment_address_line_select_o <= strap_raw[12:11];
         chip_select_count_select_o <= strap_raw[10:9];
         write_config_strap_o <= strap_raw[8];
         bootloader_select_o <= strap_raw[4];
         adapt_mode_select_o <= strap_raw[1];
         emulation_mode_o <= strap_raw[0];
      end
   end

   assign high_byte_disable = !bus_type_field[0];
   assign write_signal_config = !strap_raw[8];

   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

   // Configuration bits except powerdown_config_bit: reloaded by every reset sequence, then software owned.
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         bidir_reset_enable <= 1'b0;
         powerdown_config_bit <= 1'b0;
         einit_done <= 1'b0;
         bus_type_field <= 2'h0;
         bus_active_zero <= 1'b0;
         latch_lengthen_zero <= 1'b0;
      end else if (state != S_RUN) begin
         bidir_reset_enable <= 1'b0;
         einit_done <= 1'b0;
         if (state == S_LATCH && latch_cnt == 3'h0) begin
            if (mask[7]) begin
               bus_type_field <= boot_strap_port_i[7:6];
            end
            bus_active_zero <= external_access_pin_i;
            latch_lengthen_zero <= external_access_pin_i;
         end
      end else begin
         if (einit_i) begin
            einit_done <= 1'b1;
         end
         if (wr && wb_adr_i == `RSCL_ADR_SYSCFG && wb_sel_i[0]) begin
            if (!einit_done) begin
               bidir_reset_enable <= wb_dat_i[`RSCL_SYSCFG_BDIR];
            end
            powerdown_config_bit <= wb_dat_i[`RSCL_SYSCFG_POWERDOWN_CONFIG_BIT];
         end else if (wr && wb_adr_i == `RSCL_ADR_BUSCFG0) begin
            if (wb_sel_i[0]) begin
               bus_type_field <= wb_dat_i[`RSCL_BUSCFG_BUS_TYPE_FIELD_LO + 1:`RSCL_BUSCFG_BUS_TYPE_FIELD_LO];
            end
            if (wb_sel_i[1]) begin
               bus_active_zero <= wb_dat_i[`RSCL_BUSCFG_ACT0];
               latch_lengthen_zero <= wb_dat_i[`RSCL_BUSCFG_ALE0];
            end
         end
      end
   end

   assign system_config_register = {6'h00, high_byte_disable, 1'b0, write_signal_config, 1'b0,
      powerdown_config_bit, 1'b0, bidir_reset_enable, 3'h0};
   assign bus_config_register_zero = {5'h00, bus_active_zero, latch_lengthen_zero, 1'b0,
      bus_type_field, 6'h00};
   assign status_reg = {5'h00, mode, reset_async_o, einit_done, kind, ready_ok, state};

   // Wishbone slave: one wait state, unmapped reads return zero.
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         if (wb_adr_i == `RSCL_ADR_SYSCFG) begin
            wb_dat_o <= {16'h0000, system_config_register};
         end else if (wb_adr_i == `RSCL_ADR_BUSCFG0) begin
            wb_dat_o <= {16'h0000, bus_config_register_zero};
         end else if (wb_adr_i == `RSCL_ADR_STRAP) begin
            wb_dat_o <= {16'h0000, reset_strap_latch};
         end else if (wb_adr_i == `RSCL_ADR_STATUS) begin
            wb_dat_o <= {16'h0000, status_reg};
         end else begin
            wb_dat_o <= 32'h00000000;
         end
      end
   end

   // Ready seen at its programmed polarity during the last external access.
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ready_ok <= 1'b1;
      end else if (bus_access_end_i) begin
         ready_ok <= !ready_enable_i || (ready_pin_i == ready_polarity_i);
      end
   end

   // Power mode entry and exit.
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         mode <= M_RUN;
         pend_pdown <= 1'b0;
         mode_refused_o <= 1'b0;
      end else if (state != S_RUN) begin
         mode <= M_RUN;
         pend_pdown <= 1'b0;
         mode_refused_o <= 1'b0;
      end else begin
         mode_refused_o <= 1'b0;
         case (mode)
            M_RUN: begin
               if (idle_instr_i || power_down_instruction_i) begin
                  mode <= M_PEND;
                  pend_pdown <= power_down_instruction_i;
               end
            end
            M_PEND: begin
               if (!bus_pending_i) begin
                  if (!ready_ok) begin
                     mode <= M_RUN;
                     mode_refused_o <= 1'b1;
                  end else if (pend_pdown) begin
                     mode <= M_PDOWN;
                  end else begin
                     mode <= M_IDLE;
                  end
               end
            end
            M_IDLE: begin
               if (wake_irq_i) begin
                  mode <= M_RUN;
               end
            end
            M_PDOWN: begin
               if (wake_irq_i && powerdown_config_bit) begin
                  mode <= M_RUN;
               end
            end
            default: begin
               mode <= M_RUN;
            end
         endcase
      end
   end

   assign cpu_stop_o = (mode == M_IDLE) || (mode == M_PDOWN);
   assign periph_stop_o = (mode == M_PDOWN);
endmodule // rscl_top

// [src/rscl_defines.vh]
// Constants for the reset, strap latch and power mode block.
// Assumes a single 125 MHz CPU clock drives all logic.
`ifndef RSCL_DEFINES_VH
`define RSCL_DEFINES_VH
`define RSCL_CLK_MHZ 125
`define RSCL_SEQ_TCL 1024
`define RSCL_SEQ_CYC (`RSCL_SEQ_TCL / 2)
`define RSCL_LATCH_TCL 8
`define RSCL_LATCH_CYC (`RSCL_LATCH_TCL / 2)
`define RSCL_ADR_SYSCFG 8'h00
`define RSCL_ADR_BUSCFG0 8'h04
`define RSCL_ADR_STRAP 8'h08
`define RSCL_ADR_STATUS 8'h0c
`define RSCL_SYSCFG_BDIR 3
`define RSCL_SYSCFG_WRITE_SIGNAL_CONFIG 7
`define RSCL_SYSCFG_POWERDOWN_CONFIG_BIT 5
`define RSCL_SYSCFG_HIGH_BYTE_DISABLE 9
`define RSCL_BUSCFG_BUS_TYPE_FIELD_LO 6
`define RSCL_BUSCFG_ALE0 9
`define RSCL_BUSCFG_ACT0 10
`define RSCL_KIND_SW 3'h0
`define RSCL_KIND_WDT 3'h1
`define RSCL_KIND_SHORT 3'h2
`define RSCL_KIND_LONG 3'h3
`define RSCL_KIND_POR 3'h4
`define RSCL_MASK_SOFT 16'h1fc0
`define RSCL_CLR_SOFT 16'h003c
`define RSCL_MASK_SHORT 16'h1fff
`define RSCL_MASK_ALL 16'hffff
`endif

// [src/rscl_seq_timer.v]
// Counts the fixed internal reset sequence after a start pulse.
// Assumes start is a one-cycle pulse in the CPU clock domain.
module rscl_seq_timer #(
   parameter CYCLES = 512
) (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire start_i,
   output reg busy_o,
   output reg done_o
);
   reg [15:0] count;

   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         count <= 16'h0000;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            busy_o <= 1'b1;
            count <= CYCLES[15:0] - 16'h0001;
         end else if (busy_o) begin
            if (count == 16'h0000) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end else begin
               count <= count - 16'h0001;
            end
         end
      end
   end
endmodule // rscl_seq_timer

// [test/rscl_checker.sv]
// Assertions on the reset, strap latch and power mode block.
// Assumes it is bound to rscl_top and sees only its ports.
module rscl_checker (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire reset_input_pin_n_i,
   input wire reset_input_pin_o,
   input wire reset_input_pin_oe_o,
   input wire reset_delay_pin_high_i,
   input wire reset_delay_pulldown_o,
   input wire reset_delay_pullup_o,
   input wire sw_reset_i,
   input wire bus_pending_i,
   input wire core_reset_o,
   input wire cpu_stop_o,
   input wire periph_stop_o,
   input wire mode_refused_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [10:0] oe_cnt;
   // Counts how long the reset pin has been pulled low.
   always @(posedge sys_clk_i) begin
      if (!rst_n_i || !reset_input_pin_oe_o)
         oe_cnt <= 11'h000;
      else
         oe_cnt <= oe_cnt + 11'h001;
   end
   a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("Acknowledge missing after request.");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Acknowledge longer than one cycle.");
   a_open_drain_low: assert property (!reset_input_pin_o)
      else $error("Reset pin driven high.");
   a_pull_in_seq: assert property (reset_input_pin_oe_o |-> core_reset_o)
      else $error("Reset pin pulled outside the reset state.");
   a_seq_length: assert property ($fell(reset_input_pin_oe_o) && $past(reset_delay_pin_high_i)
      |-> oe_cnt == 11'd512)
      else $error("Reset pin pull length wrong.");
   a_rpd_pulldown: assert property (reset_delay_pulldown_o == !reset_input_pin_n_i)
      else $error("Delay pin pull-down does not follow reset pin.");
   a_pullup_run: assert property (reset_delay_pullup_o |-> !core_reset_o)
      else $error("Delay pin pull-up on during reset.");
   a_soft_reset_seq: assert property (sw_reset_i && !core_reset_o && !cpu_stop_o |=> core_reset_o)
      else $error("Software reset did not start a sequence.");
   a_pdown_stops_cpu: assert property (periph_stop_o |-> cpu_stop_o)
      else $error("Peripherals stopped while CPU runs.");
   a_stop_after_bus: assert property ($rose(cpu_stop_o) |-> !$past(bus_pending_i))
      else $error("Stopped with a bus action pending.");
   a_refuse_no_stop: assert property (mode_refused_o |-> !cpu_stop_o [*2])
      else $error("Stopped although entry was refused.");
   c_pull_done: cover property ($fell(reset_input_pin_oe_o));
   c_pdown: cover property ($rose(periph_stop_o));
   c_refused: cover property (mode_refused_o);
endmodule // rscl_checker

// [test/rscl_ext_reset.sv]
// Far side: reset pin with pull-up and external source, delay pin capacitor.
// Assumes the bench asks for an external reset through hold_low_i.
module rscl_ext_reset (
   input wire logic sys_clk_i,
   input wire logic hold_low_i,
   input wire logic pin_oe_i,
   input wire logic pin_data_i,
   input wire logic pulldown_i,
   input wire logic pullup_i,
   output wire logic pin_n_o,
   output wire logic rpd_high_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] charge = 12'h000;
   // Open drain: the pin is low when either side pulls it.
   assign pin_n_o = !(hold_low_i || (pin_oe_i === 1'b1 && !pin_data_i));
   assign rpd_high_o = charge >= 12'h400;
   // Slow discharge keeps the delay pin high through one sequence.
   always @(posedge sys_clk_i) begin
      if (pulldown_i === 1'b1 && charge != 12'h000)
         charge <= charge - 12'h001;
      else if (pullup_i === 1'b1)
         charge <= (charge > 12'h7df) ? 12'h7ff : charge + 12'h020;
   end
endmodule // rscl_ext_reset

// [test/tb_top.sv]
// Bench for the reset, strap latch and power mode block.
// Assumes a 125 MHz clock and the far-side model on the reset pins.
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 0, rst_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, ext_low = 0, refused_seen = 0;
   logic [7:0] wb_adr_i = 0;
   logic [3:0] wb_sel_i = 0;
   logic [31:0] wb_dat_i = 0, wb_dat_o;
   logic [15:0] boot_strap_port_i = 16'ha583;
   logic [6:0] pul = 0;
   logic external_access_pin_i = 1, bus_pending_i = 0, ready_enable_i = 0, ready_polarity_i = 0, ready_pin_i = 0;
   logic wb_ack_o, reset_input_pin_n_i, reset_input_pin_o, reset_input_pin_oe_o, reset_output_pin_n_o;
   logic reset_delay_pin_high_i, reset_delay_pulldown_o, reset_delay_pullup_o, core_reset_o, reset_async_o;
   logic write_config_strap_o, bootloader_select_o, adapt_mode_select_o, emulation_mode_o;
   logic cpu_stop_o, periph_stop_o, mode_refused_o;
   logic [2:0] clock_config_strap_o;
   logic [1:0] segment_address_line_select_o, chip_select_count_select_o;
   wire sw_reset_i = pul[0], wdt_reset_i = pul[1], einit_i = pul[2], idle_instr_i = pul[3];
   wire power_down_instruction_i = pul[4], wake_irq_i = pul[5], bus_access_end_i = pul[6];
   wire [10:0] strap_outs = {clock_config_strap_o, segment_address_line_select_o, chip_select_count_select_o,
      write_config_strap_o, bootloader_select_o, adapt_mode_select_o, emulation_mode_o};
   int errors = 0, samples_checked = 0;
   rscl_top dut (.*);
   rscl_ext_reset far (.sys_clk_i, .hold_low_i(ext_low), .pin_oe_i(reset_input_pin_oe_o),
      .pin_data_i(reset_input_pin_o), .pulldown_i(reset_delay_pulldown_o), .pullup_i(reset_delay_pullup_o),
      .pin_n_o(reset_input_pin_n_i), .rpd_high_o(reset_delay_pin_high_i));
   always #4 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      if (mode_refused_o === 1'b1)
         refused_seen <= 1'b1;
   end
   task stop_test;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge sys_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge sys_clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (k >= 50)
         errors++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0, q);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task pulse(input int i);
      @(posedge sys_clk_i);
      pul[i] <= 1'b1;
      @(posedge sys_clk_i);
      pul[i] <= 1'b0;
   endtask
   task wait_run;
      int k;
      k = 0;
      do begin
         @(negedge sys_clk_i);
         k++;
      end while (core_reset_o !== 1'b0 && k < 3000);
      if (k >= 3000)
         errors++;
      repeat (2) @(negedge sys_clk_i);
   endtask
   task t_por;
      logic [31:0] q;
      wait_run;
      `CHK(reset_async_o, 1'b1)
      `CHK(reset_output_pin_n_o, 1'b0)
      `CHK(strap_outs, 11'h52b)
      rd(8'h08, q);
      `CHK(q, 32'ha5)
      wr(8'h08, 32'hffff);
      rd(8'h08, q);
      `CHK(q, 32'ha5)
      rd(8'h04, q);
      `CHK(q & 32'h6c0, 32'h680)
      rd(8'h00, q);
      `CHK(q & 32'h2a8, 32'h200)
      rd(8'h10, q);
      `CHK(q, 32'h0)
      pulse(2);
      wr(8'h00, 32'h8);
      `CHK(reset_output_pin_n_o, 1'b1)
      rd(8'h00, q);
      `CHK(q[3], 1'b0)
   endtask
   task t_wdt;
      logic [31:0] q;
      @(posedge sys_clk_i);
      boot_strap_port_i <= 16'h5a7c;
      pulse(1);
      wait_run;
      `CHK(reset_async_o, 1'b1)
      `CHK(strap_outs, 11'h5d3)
      rd(8'h08, q);
      `CHK(q, 32'hba)
      rd(8'h04, q);
      `CHK(q & 32'h6c0, 32'h640)
      rd(8'h00, q);
      `CHK(q & 32'h2a8, 32'h80)
   endtask
   task t_bidir;
      int n;
      logic [31:0] q;
      wr(8'h00, 32'h28);
      rd(8'h00, q);
      `CHK(q & 32'h28, 32'h28)
      repeat (60) @(negedge sys_clk_i);
      `CHK(reset_delay_pullup_o, 1'b1)
      pulse(0);
      @(negedge sys_clk_i);
      `CHK(reset_input_pin_oe_o, 1'b1)
      `CHK(reset_delay_pulldown_o, 1'b1)
      n = 0;
      repeat (600) begin
         n += reset_input_pin_oe_o;
         @(negedge sys_clk_i);
      end
      `CHK(n, 512)
      `CHK(reset_input_pin_n_i, 1'b1)
      wait_run;
      `CHK(reset_async_o, 1'b0)
      `CHK(strap_outs, 11'h5d4)
      rd(8'h00, q);
      `CHK(q[3], 1'b0)
   endtask
   task t_power;
      wr(8'h00, 32'h20);
      bus_pending_i <= 1'b1;
      pulse(3);
      repeat (4) @(negedge sys_clk_i);
      `CHK(cpu_stop_o, 1'b0)
      @(posedge sys_clk_i);
      bus_pending_i <= 1'b0;
      repeat (2) @(negedge sys_clk_i);
      `CHK({cpu_stop_o, periph_stop_o}, 2'b10)
      pulse(5);
      pulse(4);
      repeat (2) @(negedge sys_clk_i);
      `CHK({cpu_stop_o, periph_stop_o}, 2'b11)
      pulse(5);
      repeat (2) @(negedge sys_clk_i);
      `CHK(periph_stop_o, 1'b0)
      @(posedge sys_clk_i);
      ready_enable_i <= 1'b1;
      ready_polarity_i <= 1'b1;
      refused_seen <= 1'b0;
      pulse(6);
      pulse(3);
      repeat (4) @(negedge sys_clk_i);
      `CHK({refused_seen, cpu_stop_o}, 2'b10)
   endtask
   task t_long;
      logic [31:0] q;
      @(posedge sys_clk_i);
      ext_low <= 1'b1;
      external_access_pin_i <= 1'b0;
      repeat (700) @(posedge sys_clk_i);
      ext_low <= 1'b0;
      wait_run;
      `CHK(strap_outs, 11'h2d4)
      `CHK(reset_async_o, 1'b0)
      rd(8'h04, q);
      `CHK(q & 32'h6c0, 32'h040)
   endtask
   initial begin
      repeat (16) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      t_por;
      t_wdt;
      t_bidir;
      t_power;
      t_long;
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      errors++;
      stop_test;
   end
endmodule // tb_top
bind rscl_top rscl_checker chk (.*);
